// File: hdl/battery_backup_power_mode_ctrl.sv
// Notes on behaviour
// [R1] In backup supply mode every pin output is driven to a defined low state.
// [R2] In backup supply mode only the time-keeping clock and its oscillator run.
// [R3] Backup mode is entered only when supply is under the switchover threshold and under the battery.
// [R4] Backup mode is left at once when supply rises above the battery voltage.
// [R5] While supply is under the switchover threshold all external inputs are ignored; the code gates only the pin inputs, not i_irq_buffer_read.
// [R6] The time-keeping registers are kept intact for the whole of backup mode.
// [R7] After supply returns, register writes stay blocked for the recovery write-protect time.
// [R8] After leaving battery supply the serial bus stays silent for at least 5 ms, and the host waits as long.
// [R9] At each power-up the battery is checked and an enabled low-battery alarm raises an interrupt pulse.
// [R10] While the alarm is enabled the check repeats weekly and alarms again only if still low.
// [R11] The active-low interrupt output is pulled low and held until the host reads the source buffer.
// [R12] The week is counted from the time-keeping seconds, and no alarm is raised while disabled.
`timescale 1ns/1ps
`default_nettype none

module battery_backup_power_mode_ctrl
    import bbpm_pkg::*;
#(
    parameter int unsigned NUM_PINS               = DEFAULT_NUM_PINS,
    parameter int unsigned BUS_QUIET_CYCLES_P     = BUS_QUIET_CYCLES,
    parameter int unsigned WRITE_PROTECT_CYCLES_P = RECOVERY_WRITE_PROTECT_CYCLES,
    parameter int unsigned WEEK_SECONDS           = SECONDS_PER_WEEK
) (
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst,
    input  wire logic                i_vcc_below_switchover,
    input  wire logic                i_vcc_below_vbat,
    input  wire logic                i_vbat_below_min,
    input  wire logic                i_battery_alarm_enable,
    input  wire logic                i_rtc_second_tick,
    input  wire logic                i_irq_buffer_read,
    input  wire logic [NUM_PINS-1:0] i_pin_in,
    input  wire logic [NUM_PINS-1:0] i_core_pin_out,
    input  wire logic [NUM_PINS-1:0] i_core_pin_oe,
    output logic      [NUM_PINS-1:0] o_core_pin_in,
    output logic      [NUM_PINS-1:0] o_pin_out,
    output logic      [NUM_PINS-1:0] o_pin_oe,
    output logic                     o_backup_mode,
    output logic                     o_core_clk_en,
    output logic                     o_rtc_run,
    output logic                     o_rtc_retain,
    output logic                     o_inputs_ignored,
    output logic                     o_write_blocked,
    output logic                     o_bus_blocked,
    output logic                     o_low_batt_pulse,
    output logic                     o_irq_n_out,
    output logic                     o_irq_n_oe
);

    localparam int unsigned SYNC_W = NUM_CMP + NUM_PINS;
    localparam logic [CNT_W-1:0] BUS_QUIET_LOAD = CNT_W'(BUS_QUIET_CYCLES_P);
    localparam logic [CNT_W-1:0] WRITE_PROT_LOAD = CNT_W'(WRITE_PROTECT_CYCLES_P);

    supply_mode_t mode;
    supply_mode_t next_mode;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_s1;
    logic [SYNC_W-1:0] sync_s2;
    logic [SYNC_W-1:0] sync_s3;
    logic [SYNC_W-1:0] sync_filt;

    logic              below_so;
    logic              below_vbat;
    logic              vbat_low;
    logic [NUM_PINS-1:0] pin_in_filt;

    logic [CNT_W-1:0]  bus_cnt;
    logic [CNT_W-1:0]  wp_cnt;
    logic              backup_exit;
    logic              pup_pend;
    logic              pup_evt;
    logic [SYNC_SETTLE_CYCLES-1:0] settle_sr;
    logic              settled;

    low_batt_if lb_bus ();

    // Comparator outputs and pins come from outside the clock's domain.
    // A change is taken only once the second and third stages agree.
    assign sync_in = {i_pin_in, i_vbat_below_min, i_vcc_below_vbat, i_vcc_below_switchover};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    sync_s1[gi]   <= 1'b0;
                    sync_s2[gi]   <= 1'b0;
                    sync_s3[gi]   <= 1'b0;
                    sync_filt[gi] <= 1'b0;
                end else begin
                    sync_s1[gi] <= sync_in[gi];
                    sync_s2[gi] <= sync_s1[gi];
                    sync_s3[gi] <= sync_s2[gi];
                    if (sync_s2[gi] == sync_s3[gi]) begin
                        sync_filt[gi] <= sync_s3[gi];
                    end
                end
            end
        end
    endgenerate

    assign below_so    = sync_filt[CMP_BELOW_SO];
    assign below_vbat  = sync_filt[CMP_BELOW_VBAT];
    assign vbat_low    = sync_filt[CMP_VBAT_LOW];
    assign pin_in_filt = sync_filt[SYNC_W-1:NUM_CMP];

    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_MAIN: begin
                if (below_so && below_vbat) begin
                    next_mode = MODE_BACKUP; // [R3]
                end
            end
            MODE_BACKUP: begin
                if (!below_vbat) begin
                    next_mode = MODE_RECOVER; // [R4]
                end
            end
            MODE_RECOVER: begin
                if (below_so && below_vbat) begin
                    next_mode = MODE_BACKUP; // [R3]
                end else if ((bus_cnt == CNT_ZERO) && (wp_cnt == CNT_ZERO)) begin
                    next_mode = MODE_MAIN;
                end
            end
            default: begin
                next_mode = MODE_MAIN;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            mode <= MODE_MAIN;
        end else begin
            mode <= next_mode;
        end
    end

    assign backup_exit = (mode == MODE_BACKUP) && (next_mode == MODE_RECOVER);

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            bus_cnt <= CNT_ZERO;
        end else if (backup_exit) begin
            bus_cnt <= BUS_QUIET_LOAD; // [R8]
        end else if (bus_cnt != CNT_ZERO) begin
            bus_cnt <= bus_cnt - CNT_ONE; // [R8]
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wp_cnt <= CNT_ZERO;
        end else if (backup_exit) begin
            wp_cnt <= WRITE_PROT_LOAD; // [R7]
        end else if (wp_cnt != CNT_ZERO) begin
            wp_cnt <= wp_cnt - CNT_ONE; // [R7]
        end
    end

    // The comparators read as reset values until the synchronisers fill, so the battery check does not trust
    // them before the settle register has seen as many edges as the filter needs.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            settle_sr <= '0;
        end else begin
            settle_sr <= {settle_sr[SYNC_SETTLE_CYCLES-2:0], 1'b1};
        end
    end

    assign settled = settle_sr[SYNC_SETTLE_CYCLES-1];

    // The battery check runs once the comparators are valid after reset, since a check on
    // their reset values could never see a low battery, and again on every backup exit.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pup_pend <= 1'b1;
            pup_evt  <= 1'b0;
        end else begin
            pup_evt  <= (pup_pend && settled && (next_mode != MODE_BACKUP))
                        || backup_exit; // [R9]
            if (settled) begin
                pup_pend <= 1'b0;
            end
        end
    end

    // Pins are gated one cycle after the mode changes; the glitch-free low is worth the lag.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pin_out <= '0;
            o_pin_oe  <= '0;
        end else if (mode == MODE_BACKUP) begin
            o_pin_out <= '0; // [R1]
            o_pin_oe  <= '1; // [R1]
        end else begin
            o_pin_out <= i_core_pin_out;
            o_pin_oe  <= i_core_pin_oe;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_core_pin_in <= '0;
        end else if (below_so) begin
            o_core_pin_in <= '0; // [R5]
        end else begin
            o_core_pin_in <= pin_in_filt;
        end
    end

    assign o_backup_mode    = (mode == MODE_BACKUP);
    assign o_core_clk_en    = (mode != MODE_BACKUP); // [R2]
    assign o_rtc_run        = 1'b1; // [R2]
    assign o_rtc_retain     = (mode == MODE_BACKUP); // [R6]
    assign o_inputs_ignored = below_so; // [R5]
    assign o_write_blocked  = (mode == MODE_BACKUP) || (wp_cnt != CNT_ZERO); // [R7]
    assign o_bus_blocked    = (mode == MODE_BACKUP) || (bus_cnt != CNT_ZERO); // [R8]

    // Alarm checks would read stale comparators in backup, so check_req only comes in main or recovery supply; the weekly check still runs in backup.
    assign lb_bus.check_req            = pup_evt;
    assign lb_bus.vbat_low             = vbat_low;
    assign lb_bus.battery_alarm_enable = i_battery_alarm_enable;
    assign lb_bus.second_tick          = i_rtc_second_tick;
    assign lb_bus.buffer_read          = i_irq_buffer_read;

    low_batt_monitor #(
        .WEEK_SECONDS (WEEK_SECONDS)
    ) u_low_batt_monitor (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .lb        (lb_bus.mon)
    );

    assign o_low_batt_pulse = lb_bus.alarm_pulse; // [R9]
    assign o_irq_n_out      = 1'b0;
    assign o_irq_n_oe       = !lb_bus.irq_n; // [R11]

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_backup_exit;
        (mode == MODE_BACKUP) ##1 (mode == MODE_RECOVER);
    endsequence

    chk_enter_needs_both: assert property ( // [R3]
        $rose(o_backup_mode) |-> $past(below_so) && $past(below_vbat))
        else $error("Backup entered without both comparator conditions.");

    chk_exit_immediate: assert property ( // [R4]
        o_backup_mode && !below_vbat |=> !o_backup_mode)
        else $error("Backup not left when supply rose above battery.");

    chk_pins_forced_low: assert property ( // [R1]
        o_backup_mode |=> (o_pin_out == '0) && (o_pin_oe == '1))
        else $error("Pins not driven low in backup mode.");

    chk_logic_gated: assert property ( // [R2]
        o_backup_mode |-> !o_core_clk_en && o_rtc_run)
        else $error("Core logic running in backup mode.");

    chk_inputs_ignored: assert property ( // [R5]
        below_so |-> o_inputs_ignored ##1 (o_core_pin_in == '0))
        else $error("Inputs passed while under switchover threshold.");

    chk_rtc_retained: assert property ( // [R6]
        o_backup_mode |-> o_rtc_retain && o_rtc_run)
        else $error("Time-keeping registers not retained in backup.");

    chk_write_protect: assert property ( // [R7]
        s_backup_exit |-> (wp_cnt == WRITE_PROT_LOAD) && o_write_blocked)
        else $error("Write protect not loaded on return to main supply.");

    chk_bus_quiet: assert property ( // [R8]
        s_backup_exit |-> (bus_cnt == BUS_QUIET_LOAD) ##1 o_bus_blocked [*8])
        else $error("Serial bus released too early after battery exit.");

    chk_powerup_check: assert property ( // [R9]
        s_backup_exit |-> pup_evt)
        else $error("No battery check after return to main supply.");

    chk_check_settled: assert property ( // [R9]
        !settled && !backup_exit |=> !pup_evt)
        else $error("Battery check issued before the comparators settled.");

    chk_pins_follow_core: assert property ( // [R1]
        !o_backup_mode |=> (o_pin_out == $past(i_core_pin_out))
        && (o_pin_oe == $past(i_core_pin_oe)))
        else $error("Pins did not follow the core outside backup mode.");

    chk_wp_countdown: assert property ( // [R7]
        (wp_cnt != CNT_ZERO) && !backup_exit |=> (wp_cnt == $past(wp_cnt) - CNT_ONE))
        else $error("Write protect time not counted down cycle by cycle.");

    chk_bus_countdown: assert property ( // [R8]
        (bus_cnt != CNT_ZERO) && !backup_exit |=> (bus_cnt == $past(bus_cnt) - CNT_ONE))
        else $error("Bus quiet time not counted down cycle by cycle.");

    chk_recover_done: assert property ( // [R7]
        (mode == MODE_RECOVER) && (bus_cnt == CNT_ZERO) && (wp_cnt == CNT_ZERO)
        && !(below_so && below_vbat) |=> (mode == MODE_MAIN) && !o_write_blocked)
        else $error("Main supply not resumed after the recovery time.");

endmodule // battery_backup_power_mode_ctrl

`default_nettype wire

// File: hdl/bbpm_pkg.sv
package bbpm_pkg;

    localparam int unsigned CLK_FREQ_MHZ       = 100;
    localparam int unsigned BUS_QUIET_TIME_MS  = 5;
    localparam int unsigned BUS_QUIET_CYCLES   = BUS_QUIET_TIME_MS * 1000 * CLK_FREQ_MHZ;
    localparam int unsigned RECOVERY_WRITE_PROTECT_TIME_US = 1000;
    localparam int unsigned RECOVERY_WRITE_PROTECT_CYCLES  =
        RECOVERY_WRITE_PROTECT_TIME_US * CLK_FREQ_MHZ;
    localparam int unsigned SECONDS_PER_WEEK   = 604800;

    localparam int unsigned CNT_W              = 32;
    localparam int unsigned DEFAULT_NUM_PINS   = 16;

    localparam int unsigned CMP_BELOW_SO       = 0;
    localparam int unsigned CMP_BELOW_VBAT     = 1;
    localparam int unsigned CMP_VBAT_LOW       = 2;
    localparam int unsigned NUM_CMP            = 3;
    localparam int unsigned SYNC_SETTLE_CYCLES = 4;

    localparam logic [CNT_W-1:0] CNT_ZERO      = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE       = 32'h0000_0001;

    typedef enum logic [1:0] {
        MODE_MAIN,
        MODE_BACKUP,
        MODE_RECOVER
    } supply_mode_t;

endpackage

// File: hdl/low_batt_if.sv
`timescale 1ns/1ps
`default_nettype none

interface low_batt_if;
    logic check_req;
    logic vbat_low;
    logic battery_alarm_enable;
    logic second_tick;
    logic buffer_read;
    logic irq_n;
    logic alarm_pulse;

    modport ctrl (
        output check_req,
        output vbat_low,
        output battery_alarm_enable,
        output second_tick,
        output buffer_read,
        input  irq_n,
        input  alarm_pulse
    );

    modport mon (
        input  check_req,
        input  vbat_low,
        input  battery_alarm_enable,
        input  second_tick,
        input  buffer_read,
        output irq_n,
        output alarm_pulse
    );
endinterface

`default_nettype wire

// File: hdl/low_batt_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module low_batt_monitor
    import bbpm_pkg::*;
#(
    parameter int unsigned WEEK_SECONDS = SECONDS_PER_WEEK
) (
    input  wire logic  i_clk_sys,
    input  wire logic  i_rst,
    low_batt_if.mon    lb
);

    logic [CNT_W-1:0] sec_cnt;
    logic             week_due;
    logic             check_now;
    logic             alarm_pulse;
    logic             irq_latched;

    localparam logic [CNT_W-1:0] WEEK_LAST = CNT_W'(WEEK_SECONDS - 1);

    // The week is counted in whole seconds from the time-keeping tick.
    assign week_due  = lb.battery_alarm_enable && lb.second_tick
                       && (sec_cnt == WEEK_LAST); // [R12]
    assign check_now = lb.check_req || week_due; // [R9] [R10]

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sec_cnt <= CNT_ZERO;
        end else if (!lb.battery_alarm_enable) begin
            sec_cnt <= CNT_ZERO; // [R12]
        end else if (lb.second_tick) begin
            sec_cnt <= week_due ? CNT_ZERO : sec_cnt + CNT_ONE; // [R10]
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            alarm_pulse <= 1'b0;
        end else begin
            alarm_pulse <= check_now && lb.battery_alarm_enable && lb.vbat_low; // [R9] [R10] [R12]
        end
    end

    // A new alarm in the cycle of the buffer read wins, so it is never lost.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            irq_latched <= 1'b0;
        end else if (alarm_pulse) begin
            irq_latched <= 1'b1; // [R11]
        end else if (lb.buffer_read) begin
            irq_latched <= 1'b0; // [R11]
        end
    end

    assign lb.alarm_pulse = alarm_pulse;
    assign lb.irq_n       = !irq_latched;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_check_low;
        lb.check_req && lb.battery_alarm_enable && lb.vbat_low;
    endsequence

    chk_powerup_alarm: assert property (s_check_low |=> alarm_pulse ##1 !lb.irq_n) // [R9]
        else $error("Low battery at power-up check gave no alarm.");

    chk_weekly_alarm: assert property (week_due && lb.vbat_low |=> alarm_pulse) // [R10]
        else $error("Weekly recheck with low battery gave no alarm.");

    chk_irq_held: assert property (!lb.irq_n && !lb.buffer_read |=> !lb.irq_n) // [R11]
        else $error("Interrupt released before the buffer was read.");

    chk_alarm_disabled: assert property (!$past(lb.battery_alarm_enable) |-> !alarm_pulse) // [R12]
        else $error("Alarm pulse while the alarm enable was clear.");

endmodule // low_batt_monitor

`default_nettype wire

// File: dv/supply_comparator_model.sv
`timescale 1ns/1ps
`default_nettype none

// Ideal comparators with no hysteresis, so a bench level exactly on a threshold is not used.
module supply_comparator_model #(
    parameter int SWITCHOVER_MV = 3500,
    parameter int VBAT_MIN_MV   = 2500
) (
    input  var int   i_vcc_mv,
    input  var int   i_vbat_mv,
    output logic     o_below_switchover,
    output logic     o_below_vbat,
    output logic     o_vbat_below_min
);
    assign o_below_switchover = (i_vcc_mv < SWITCHOVER_MV);
    assign o_below_vbat       = (i_vcc_mv < i_vbat_mv);
    assign o_vbat_below_min   = (i_vbat_mv < VBAT_MIN_MV);
endmodule // supply_comparator_model

`default_nettype wire

// File: dv/tb_battery_backup_power_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_battery_backup_power_mode_ctrl;
    import bbpm_pkg::*;
    localparam int NP = 4;
    localparam int BQ = 20;
    localparam int WP = 12;
    localparam int WK = 3;
    logic          clk_sys = 1'b0;
    logic          rst = 1'b1;
    logic          alarm_en = 1'b0;
    logic          tick = 1'b0;
    logic          buf_rd = 1'b0;
    logic [NP-1:0] pin_in = 4'h0;
    logic [NP-1:0] core_out = 4'h0;
    logic [NP-1:0] core_oe = 4'h0;
    logic [NP-1:0] core_pin_in, pin_out, pin_oe;
    logic          below_so, below_vbat, vbat_low, backup, clk_en, rtc_run, retain;
    logic          ignored, wr_blk, bus_blk, lb_pulse, irq_out, irq_oe;
    int            vcc_mv = 5000;
    int            vbat_mv = 3000;
    int            err_count = 0;
    int            n_checks = 0;
    int            pulse_count = 0;

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (lb_pulse === 1'b1) pulse_count++;

    supply_comparator_model cmp (.i_vcc_mv(vcc_mv), .i_vbat_mv(vbat_mv),
        .o_below_switchover(below_so), .o_below_vbat(below_vbat), .o_vbat_below_min(vbat_low));

    battery_backup_power_mode_ctrl #(.NUM_PINS(NP), .BUS_QUIET_CYCLES_P(BQ),
        .WRITE_PROTECT_CYCLES_P(WP), .WEEK_SECONDS(WK)) DUT (
        .i_clk_sys(clk_sys), .i_rst(rst), .i_vcc_below_switchover(below_so),
        .i_vcc_below_vbat(below_vbat), .i_vbat_below_min(vbat_low),
        .i_battery_alarm_enable(alarm_en), .i_rtc_second_tick(tick),
        .i_irq_buffer_read(buf_rd), .i_pin_in(pin_in), .i_core_pin_out(core_out),
        .i_core_pin_oe(core_oe), .o_core_pin_in(core_pin_in), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .o_backup_mode(backup), .o_core_clk_en(clk_en),
        .o_rtc_run(rtc_run), .o_rtc_retain(retain), .o_inputs_ignored(ignored),
        .o_write_blocked(wr_blk), .o_bus_blocked(bus_blk), .o_low_batt_pulse(lb_pulse),
        .o_irq_n_out(irq_out), .o_irq_n_oe(irq_oe));

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic fail(string msg);
        err_count++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask

    task automatic check_bit(logic got, logic exp, string msg);
        n_checks++;
        if (got !== exp) fail(msg);
    endtask

    task automatic check_vec(logic [NP-1:0] got, logic [NP-1:0] exp, string msg);
        n_checks++;
        if (got !== exp) fail(msg);
    endtask

    task automatic check_int(int got, int lo, int hi, string msg);
        n_checks++;
        if (got < lo || got > hi) fail(msg);
    endtask

    // All bench drives land 1 ns after a rising edge, clear of the sampling instant.
    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_mode(logic exp);
        for (int i = 0; i < 20; i++) begin
            if (backup === exp) return;
            step(1);
        end
        fail("supply mode did not change");
        stop_test();
    endtask

    task automatic ticks(int n);
        repeat (n) begin
            tick = 1'b1;
            step(1);
            tick = 1'b0;
            step(3);
        end
    endtask

    task automatic read_buffer();
        buf_rd = 1'b1;
        step(1);
        buf_rd = 1'b0;
        step(2);
    endtask

    task automatic t_reset();
        check_bit(backup, 1'b0, "mode after reset");
        check_bit(clk_en, 1'b1, "core clock after reset");
        check_bit(irq_oe, 1'b0, "irq after reset");
        check_bit(irq_out, 1'b0, "irq drive value");
    endtask

    task automatic t_pins_main();
        core_out = 4'hA;
        core_oe  = 4'h5;
        pin_in   = 4'h6;
        step(6);
        check_vec(pin_out, 4'hA, "pin out in main");
        check_vec(pin_oe, 4'h5, "pin oe in main");
        check_vec(core_pin_in, 4'h6, "pin in in main");
    endtask

    task automatic t_one_condition();
        vcc_mv  = 3000;
        vbat_mv = 2000;
        step(8);
        check_bit(backup, 1'b0, "backup on low supply alone");
        check_bit(ignored, 1'b1, "inputs not ignored");
        check_vec(core_pin_in, 4'h0, "input passed while low");
        vcc_mv  = 4000;
        vbat_mv = 4500;
        step(8);
        check_bit(backup, 1'b0, "backup on battery above supply alone");
        check_bit(ignored, 1'b0, "inputs ignored above threshold");
        vcc_mv  = 5000;
        vbat_mv = 2000;
        step(8);
    endtask

    task automatic t_backup_entry();
        alarm_en = 1'b1;
        core_out = 4'hF;
        vcc_mv   = 1000;
        wait_mode(1'b1);
        step(2);
        check_bit(clk_en, 1'b0, "core clock in backup");
        check_bit(rtc_run, 1'b1, "rtc stopped");
        check_bit(retain, 1'b1, "rtc not retained");
        check_vec(pin_out, 4'h0, "pin out in backup");
        check_vec(pin_oe, 4'hF, "pin oe in backup");
        check_vec(core_pin_in, 4'h0, "pin in in backup");
        check_bit(wr_blk, 1'b1, "writes open in backup");
        check_bit(bus_blk, 1'b1, "bus open in backup");
    endtask

    task automatic t_backup_exit();
        int p0 = pulse_count;
        int wb = 0;
        int bb = 0;
        vcc_mv = 5000;
        wait_mode(1'b0);
        check_bit(clk_en, 1'b1, "core clock after exit");
        for (int i = 0; i < 100 && (bus_blk === 1'b1 || wr_blk === 1'b1); i++) begin
            bb += (bus_blk === 1'b1);
            wb += (wr_blk === 1'b1);
            step(1);
        end
        check_int(wb, WP, WP, "write block length");
        check_int(bb, BQ, BQ, "bus block length");
        check_int(pulse_count, p0 + 1, p0 + 1, "power-up alarm count");
        check_bit(irq_oe, 1'b1, "irq not held");
        read_buffer();
        check_bit(irq_oe, 1'b0, "irq not released by read");
    endtask

    task automatic t_weekly();
        int p0;
        alarm_en = 1'b0;
        step(2);
        alarm_en = 1'b1;
        step(1);
        p0 = pulse_count;
        ticks(WK - 1);
        check_int(pulse_count, p0, p0, "recheck too early");
        ticks(1);
        check_int(pulse_count, p0 + 1, p0 + 1, "weekly recheck missing");
        check_bit(irq_oe, 1'b1, "weekly irq missing");
        read_buffer();
        alarm_en = 1'b0;
        ticks(2 * WK);
        check_int(pulse_count, p0 + 1, p0 + 1, "alarm while disabled");
        check_bit(irq_oe, 1'b0, "irq while disabled");
        alarm_en = 1'b1;
        vbat_mv  = 3000;
        step(8);
        ticks(WK);
        check_int(pulse_count, p0 + 1, p0 + 1, "alarm on good battery");
    endtask

    // A second power-up by reset with a low battery must still raise the alarm.
    task automatic t_reset_alarm();
        int p0 = pulse_count;
        vbat_mv = 2000;
        step(8);
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        step(1);
        check_bit(backup, 1'b0, "mode after second reset");
        check_bit(irq_oe, 1'b0, "irq after second reset");
        step(9);
        check_int(pulse_count, p0 + 1, p0 + 1, "power-up alarm after reset");
        check_bit(irq_oe, 1'b1, "reset alarm irq missing");
        read_buffer();
    endtask

    initial begin
        #200us;
        fail("run did not finish");
        stop_test();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        step(2);
        t_reset();
        t_pins_main();
        t_one_condition();
        t_backup_entry();
        t_backup_exit();
        t_weekly();
        t_reset_alarm();
        stop_test();
    end
endmodule // tb_battery_backup_power_mode_ctrl

`default_nettype wire
